// [include/swr_params.svh]
// Timing and field constants shared by both ends of the single-wire link.
// Assumes a 50 MHz clock; times are in ns and turned into cycles by swr_pkg.
// Function
// - Both ends only pull low or release.
// - Single-wire mode from setting or subcommand.
// - Apply-selection subcommand switches to configured interface.
// - Force subcommand switches to single-wire at once.
// - Bytes go least significant bit first.
// - Command is 7-bit code plus direction bit 7.
// - Device receives or sends eight data bits.
// - Device only responds, never starts a transaction.
// - Host opens with break then recovery time.
// - Host sends command as eight host slots.
// - Eight data slots, timed by the driving side.
// - One data byte per transaction, no increment.
`ifndef SWR_PARAMS_SVH
`define SWR_PARAMS_SVH

`define SWR_CLK_NS          20
`define SWR_CNT_W           14
`define SWR_BYTE_W          8
`define SWR_CODE_W          7
`define SWR_DIR_BIT         7
`define SWR_BREAK_NS        80000
`define SWR_BREAK_MIN_NS    60000
`define SWR_RECOVERY_NS     20000
`define SWR_HOST_SLOT_NS    60000
`define SWR_HOST_ZERO_NS    40000
`define SWR_HOST_ONE_NS     10000
`define SWR_DEV_SLOT_NS     60000
`define SWR_DEV_ZERO_NS     40000
`define SWR_DEV_ONE_NS      10000
`define SWR_BIT_THR_NS      25000
`define SWR_RD_TIMEOUT_NS   150000

`endif

// [include/swr_pkg.sv]
// Types and helper functions for both ends of the single-wire link.
// Assumes swr_params.svh is on the include path.
`include "swr_params.svh"
package swr_pkg;
   typedef logic [`SWR_CNT_W-1:0]  swr_cnt_t;
   typedef logic [`SWR_BYTE_W-1:0] swr_byte_t;
   typedef logic [`SWR_CODE_W-1:0] swr_code_t;

   typedef enum logic [2:0] {
      DS_IDLE    = 3'b000,
      DS_RX      = 3'b001,
      DS_RD_WAIT = 3'b010,
      DS_TX_LOW  = 3'b011,
      DS_TX_HIGH = 3'b100
   } swr_dev_st_t;

   typedef enum logic [2:0] {
      HS_IDLE    = 3'b000,
      HS_BREAK   = 3'b001,
      HS_RECOV   = 3'b010,
      HS_TX_LOW  = 3'b011,
      HS_TX_HIGH = 3'b100,
      HS_RX      = 3'b101
   } swr_host_st_t;

   // Least time: rounds up, never below one cycle.
   function automatic swr_cnt_t swr_cyc_up(input int ns);
      int c;
      c = (ns + `SWR_CLK_NS - 1) / `SWR_CLK_NS;
      return (c < 1) ? swr_cnt_t'(1) : swr_cnt_t'(c);
   endfunction

   // Longest time: rounds down, never below one cycle.
   function automatic swr_cnt_t swr_cyc_dn(input int ns);
      int c;
      c = ns / `SWR_CLK_NS;
      return (c < 1) ? swr_cnt_t'(1) : swr_cnt_t'(c);
   endfunction

   // A low pulse shorter than the threshold carries a one.
   function automatic logic swr_short_pulse(input swr_cnt_t len, input swr_cnt_t thr);
      return len < thr;
   endfunction
endpackage

// [include/swr_if.sv]
// Shared open-drain line between host and device.
// The line is high unless an enabled driver pulls it low.
`timescale 1ns/10ps
interface swr_if;
   logic host_out;
   logic host_oe;
   logic dev_out;
   logic dev_oe;
   logic line;

   assign line = ~((host_oe & ~host_out) | (dev_oe & ~dev_out));

   modport host (output host_out, output host_oe, input line);
   modport dev  (output dev_out, output dev_oe, input line);
endinterface

// [hw/swr_dev.sv]
// Device end of the single-wire return-to-one link.
// Assumes the line input is synchronous to MCLK and the host keeps its timing.
`timescale 1ns/10ps
`include "swr_params.svh"
module swr_dev
   import swr_pkg::*;
#(
   parameter int HOST_SLOT_NS = `SWR_HOST_SLOT_NS,
   parameter int DEV_SLOT_NS  = `SWR_DEV_SLOT_NS,
   parameter int DEV_ZERO_NS  = `SWR_DEV_ZERO_NS,
   parameter int DEV_ONE_NS   = `SWR_DEV_ONE_NS,
   parameter int BREAK_MIN_NS = `SWR_BREAK_MIN_NS,
   parameter int BIT_THR_NS   = `SWR_BIT_THR_NS
) (
   // Clock and reset.
   input  wire logic      MCLK,
   input  wire logic      RESET,
   // Shared line.
   swr_if.dev             LINK,
   // Interface selection.
   input  wire logic      CFG_SINGLE_WIRE,
   input  wire logic      APPLY_SEL_CMD,
   input  wire logic      FORCE_SINGLE_WIRE_CMD,
   output logic           SW_MODE,
   // Write data towards the core.
   output logic           WR_VALID,
   input  wire logic      WR_READY,
   output swr_code_t      WR_CODE,
   output swr_byte_t      WR_DATA,
   // Read request and reply.
   output logic           RD_REQ,
   output swr_code_t      RD_CODE,
   input  wire logic      RD_VALID,
   input  wire swr_byte_t RD_DATA
);
   localparam swr_cnt_t HSLOT     = swr_cyc_up(HOST_SLOT_NS);
   localparam swr_cnt_t DSLOT_M1  = swr_cyc_up(DEV_SLOT_NS) - swr_cnt_t'(1);
   localparam swr_cnt_t DZERO_M1  = swr_cyc_up(DEV_ZERO_NS) - swr_cnt_t'(1);
   localparam swr_cnt_t DONE_M1   = swr_cyc_up(DEV_ONE_NS) - swr_cnt_t'(1);
   localparam swr_cnt_t BRK_MIN   = swr_cyc_up(BREAK_MIN_NS);
   localparam swr_cnt_t BIT_THR   = swr_cyc_up(BIT_THR_NS);
   localparam logic [3:0] LAST_CMD  = 4'(`SWR_BYTE_W - 1);
   localparam logic [3:0] LAST_DATA = 4'(2 * `SWR_BYTE_W - 1);
   localparam int       WORD_W    = `SWR_CODE_W + `SWR_BYTE_W;
   localparam logic [1:0] FULL    = 2'h2;

   swr_dev_st_t       st_q;
   swr_dev_st_t       st_d;
   logic              active_q;
   logic              strap_done_q;
   logic              line_q;
   swr_cnt_t          low_q;
   swr_cnt_t          cnt_q;
   logic [3:0]        bit_q;
   swr_byte_t         sr_q;
   swr_code_t         code_q;
   swr_code_t         rd_code_q;
   swr_byte_t         tx_q;
   logic              rd_have_q;
   logic              rd_req_q;
   logic              dev_oe_q;
   logic [WORD_W-1:0] buf_q [2];
   logic [1:0]        fill_q;
   logic              wr_valid_q;

   wire               rise;
   wire               is_break;
   wire               rx_bit;
   wire               rx_take;
   wire swr_byte_t    sr_next;
   wire               cmd_done;
   wire               wr_done;
   wire               tx_bit;
   wire swr_cnt_t     pulse_m1;
   wire               buf_free;
   wire               push;
   wire               pop;
   wire [1:0]         fill_d;
   wire [WORD_W-1:0]  wr_word;
   wire               cnt_clr;

   assign rise     = ~line_q & LINK.line;
   assign is_break = rise & (low_q >= BRK_MIN);
   assign rx_bit   = swr_short_pulse(low_q, BIT_THR);
   assign rx_take  = rise & ~is_break & (st_q == DS_RX);
   assign sr_next  = {rx_bit, sr_q[`SWR_BYTE_W-1:1]};
   assign cmd_done = rx_take & (bit_q == LAST_CMD);
   assign wr_done  = rx_take & (bit_q == LAST_DATA);
   assign tx_bit   = tx_q[bit_q[2:0]];
   assign pulse_m1 = tx_bit ? DONE_M1 : DZERO_M1;
   assign buf_free = (fill_q != FULL);
   assign push     = wr_done;
   assign pop      = wr_valid_q & WR_READY;
   assign fill_d   = 2'(fill_q + {1'b0, push} - {1'b0, pop});
   assign wr_word  = {code_q, sr_next};
   assign cnt_clr  = (st_d != st_q) & (st_d != DS_TX_HIGH);

   // open drain, only low or released
   assign LINK.dev_out = 1'b0;
   assign LINK.dev_oe  = dev_oe_q;

   assign SW_MODE  = active_q;
   assign WR_VALID = wr_valid_q;
   assign WR_CODE  = buf_q[0][WORD_W-1:`SWR_BYTE_W];
   assign WR_DATA  = buf_q[0][`SWR_BYTE_W-1:0];
   assign RD_REQ   = rd_req_q;
   assign RD_CODE  = rd_code_q;

   // Configured selection is taken in the cycle after reset release.
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         active_q     <= 1'b0;
         strap_done_q <= 1'b0;
      end else begin
         strap_done_q <= 1'b1;
         if (FORCE_SINGLE_WIRE_CMD) begin
            active_q <= 1'b1;
         end else if (APPLY_SEL_CMD | ~strap_done_q) begin
            active_q <= CFG_SINGLE_WIRE;
         end
      end
   end

   always_comb begin
      st_d = st_q;
      case (st_q)
         // only a host break opens a transaction
         DS_IDLE: begin
            if (is_break & buf_free) st_d = DS_RX;
         end
         DS_RX: begin
            if (cmd_done & ~sr_next[`SWR_DIR_BIT]) st_d = DS_RD_WAIT;
            else if (wr_done) st_d = DS_IDLE;
         end
         DS_RD_WAIT: begin
            if (rd_have_q & (cnt_q >= HSLOT)) st_d = DS_TX_LOW;
         end
         // device pulse then release to slot end
         DS_TX_LOW: begin
            if (cnt_q == pulse_m1) st_d = DS_TX_HIGH;
         end
         // one byte, then back to idle
         DS_TX_HIGH: begin
            if (cnt_q == DSLOT_M1) st_d = (bit_q[2:0] == 3'h7) ? DS_IDLE : DS_TX_LOW;
         end
         default: begin
            st_d = DS_IDLE;
         end
      endcase
      if (!active_q) st_d = DS_IDLE;
   end

   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         st_q     <= DS_IDLE;
         line_q   <= 1'b1;
         low_q    <= '0;
         cnt_q    <= '0;
         dev_oe_q <= 1'b0;
      end else begin
         st_q     <= st_d;
         line_q   <= LINK.line;
         low_q    <= LINK.line ? '0 : ((&low_q) ? low_q : low_q + swr_cnt_t'(1));
         cnt_q    <= cnt_clr ? '0 : ((&cnt_q) ? cnt_q : cnt_q + swr_cnt_t'(1));
         dev_oe_q <= (st_d == DS_TX_LOW);
      end
   end

   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         bit_q     <= '0;
         sr_q      <= '0;
         code_q    <= '0;
         rd_code_q <= '0;
         rd_req_q  <= 1'b0;
      end else begin
         if (is_break) bit_q <= '0;
         else if (rx_take) bit_q <= bit_q + 4'h1;
         else if ((st_q == DS_TX_HIGH) & (st_d == DS_TX_LOW)) bit_q <= bit_q + 4'h1;
         if (rx_take) sr_q <= sr_next;
         // low seven bits are the code
         if (cmd_done) code_q <= sr_next[`SWR_CODE_W-1:0];
         if (cmd_done & ~sr_next[`SWR_DIR_BIT]) rd_code_q <= sr_next[`SWR_CODE_W-1:0];
         // ask the core for read data
         rd_req_q <= cmd_done & ~sr_next[`SWR_DIR_BIT] & active_q;
      end
   end

   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         rd_have_q <= 1'b0;
         tx_q      <= '0;
      end else if (st_q != DS_RD_WAIT) begin
         rd_have_q <= 1'b0;
      end else if (RD_VALID & ~rd_have_q) begin
         rd_have_q <= 1'b1;
         tx_q      <= RD_DATA;
      end
   end

   // write byte lands in a two-entry buffer
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         buf_q[0]   <= '0;
         buf_q[1]   <= '0;
         fill_q     <= '0;
         wr_valid_q <= 1'b0;
      end else begin
         if (pop) buf_q[0] <= (fill_q == FULL) ? buf_q[1] : wr_word;
         else if (push & (fill_q == 2'h0)) buf_q[0] <= wr_word;
         if (push & (fill_q == 2'h1) & ~pop) buf_q[1] <= wr_word;
         fill_q     <= fill_d;
         wr_valid_q <= (fill_d != 2'h0);
      end
   end
endmodule

// [hw/swr_host.sv]
// Host end of the single-wire return-to-one link.
// Assumes the line input is synchronous to MCLK and the device keeps its timing.
`timescale 1ns/10ps
`include "swr_params.svh"
module swr_host
   import swr_pkg::*;
#(
   parameter int BREAK_NS      = `SWR_BREAK_NS,
   parameter int RECOVERY_NS   = `SWR_RECOVERY_NS,
   parameter int HOST_SLOT_NS  = `SWR_HOST_SLOT_NS,
   parameter int HOST_ZERO_NS  = `SWR_HOST_ZERO_NS,
   parameter int HOST_ONE_NS   = `SWR_HOST_ONE_NS,
   parameter int BIT_THR_NS    = `SWR_BIT_THR_NS,
   parameter int RD_TIMEOUT_NS = `SWR_RD_TIMEOUT_NS
) (
   // Clock and reset.
   input  wire logic      MCLK,
   input  wire logic      RESET,
   // Shared line.
   swr_if.host            LINK,
   // Request.
   input  wire logic      REQ_VALID,
   output logic           REQ_READY,
   input  wire logic      REQ_WRITE,
   input  wire swr_code_t REQ_CODE,
   input  wire swr_byte_t REQ_DATA,
   // Reply.
   output logic           RSP_VALID,
   output logic           RSP_TIMEOUT,
   output swr_byte_t      RSP_DATA
);
   localparam swr_cnt_t BRK_M1   = swr_cyc_up(BREAK_NS) - swr_cnt_t'(1);
   localparam swr_cnt_t REC_M1   = swr_cyc_up(RECOVERY_NS) - swr_cnt_t'(1);
   localparam swr_cnt_t SLOT_M1  = swr_cyc_up(HOST_SLOT_NS) - swr_cnt_t'(1);
   localparam swr_cnt_t ZERO_M1  = swr_cyc_up(HOST_ZERO_NS) - swr_cnt_t'(1);
   localparam swr_cnt_t ONE_M1   = swr_cyc_up(HOST_ONE_NS) - swr_cnt_t'(1);
   localparam swr_cnt_t BIT_THR  = swr_cyc_up(BIT_THR_NS);
   localparam swr_cnt_t TIMEOUT  = swr_cyc_dn(RD_TIMEOUT_NS);
   localparam logic [3:0] LAST_CMD  = 4'(`SWR_BYTE_W - 1);
   localparam logic [3:0] LAST_DATA = 4'(2 * `SWR_BYTE_W - 1);

   swr_host_st_t st_q;
   swr_host_st_t st_d;
   logic [2*`SWR_BYTE_W-1:0] tx_q;
   logic [3:0]   bit_q;
   swr_cnt_t     cnt_q;
   swr_cnt_t     low_q;
   logic         line_q;
   logic         oe_q;
   logic         ready_q;
   logic         rsp_q;
   logic         tmo_q;
   swr_byte_t    rx_q;

   wire          rise;
   wire          tx_bit;
   wire swr_cnt_t pulse_m1;
   wire          slot_end;
   wire          last_tx;
   wire          rx_take;
   wire          rx_last;
   wire          rx_tmo;
   wire          cnt_clr;

   assign rise     = ~line_q & LINK.line;
   assign tx_bit   = tx_q[bit_q];
   assign pulse_m1 = tx_bit ? ONE_M1 : ZERO_M1;
   assign slot_end = (st_q == HS_TX_HIGH) & (cnt_q == SLOT_M1);
   // a write carries one data byte after the command
   assign last_tx  = tx_q[`SWR_DIR_BIT] ? (bit_q == LAST_DATA) : (bit_q == LAST_CMD);
   assign rx_take  = (st_q == HS_RX) & rise;
   assign rx_last  = rx_take & (bit_q == LAST_DATA);
   assign rx_tmo   = (st_q == HS_RX) & (cnt_q == TIMEOUT);
   assign cnt_clr  = ((st_d != st_q) & (st_d != HS_TX_HIGH)) | rx_take;

   // open drain, only low or released
   assign LINK.host_out = 1'b0;
   assign LINK.host_oe  = oe_q;

   assign REQ_READY   = ready_q;
   assign RSP_VALID   = rsp_q;
   assign RSP_TIMEOUT = tmo_q;
   assign RSP_DATA    = rx_q;

   always_comb begin
      st_d = st_q;
      case (st_q)
         HS_IDLE: begin
            if (REQ_VALID & ready_q) st_d = HS_BREAK;
         end
         HS_BREAK: begin
            if (cnt_q == BRK_M1) st_d = HS_RECOV;
         end
         HS_RECOV: begin
            if (cnt_q == REC_M1) st_d = HS_TX_LOW;
         end
         // host pulse then release to slot end
         HS_TX_LOW: begin
            if (cnt_q == pulse_m1) st_d = HS_TX_HIGH;
         end
         HS_TX_HIGH: begin
            if (slot_end) begin
               if (!last_tx) st_d = HS_TX_LOW;
               else st_d = tx_q[`SWR_DIR_BIT] ? HS_IDLE : HS_RX;
            end
         end
         HS_RX: begin
            if (rx_last | rx_tmo) st_d = HS_IDLE;
         end
         default: begin
            st_d = HS_IDLE;
         end
      endcase
   end

   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         st_q    <= HS_IDLE;
         cnt_q   <= '0;
         low_q   <= '0;
         line_q  <= 1'b1;
         oe_q    <= 1'b0;
         ready_q <= 1'b0;
      end else begin
         st_q    <= st_d;
         cnt_q   <= cnt_clr ? '0 : ((&cnt_q) ? cnt_q : cnt_q + swr_cnt_t'(1));
         low_q   <= LINK.line ? '0 : ((&low_q) ? low_q : low_q + swr_cnt_t'(1));
         line_q  <= LINK.line;
         oe_q    <= (st_d == HS_BREAK) | (st_d == HS_TX_LOW);
         ready_q <= (st_d == HS_IDLE);
      end
   end

   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         tx_q  <= '0;
         bit_q <= '0;
         rx_q  <= '0;
         rsp_q <= 1'b0;
         tmo_q <= 1'b0;
      end else begin
         // direction in bit 7 above the code
         if ((st_q == HS_IDLE) & (st_d == HS_BREAK)) begin
            tx_q  <= {REQ_DATA, REQ_WRITE, REQ_CODE};
            bit_q <= '0;
            tmo_q <= 1'b0;
         end else if (slot_end | rx_take) begin
            bit_q <= bit_q + 4'h1;
         end
         if (rx_take) rx_q <= {swr_short_pulse(low_q, BIT_THR), rx_q[`SWR_BYTE_W-1:1]};
         rsp_q <= (st_q != HS_IDLE) & (st_d == HS_IDLE);
         if (rx_tmo) tmo_q <= 1'b1;
      end
   end
endmodule

// [tb/swr_link_assertions.sv]
// Assertions on the shared single-wire line between the host and device ends.
// Assumes the cycle counts match the ns parameters given to both ends.
`timescale 1ns/10ps
module swr_link_assertions #(
   parameter int BRK_CYC  = 100,
   parameter int REC_CYC  = 20,
   parameter int SLOT_CYC = 60,
   parameter int ZERO_CYC = 40,
   parameter int ONE_CYC  = 10
) (
   // Clock and reset.
   input wire logic MCLK,
   input wire logic RESET,
   // Line drivers and resolved line.
   input wire logic host_out,
   input wire logic host_oe,
   input wire logic dev_out,
   input wire logic dev_oe,
   input wire logic line
);
   logic [7:0] hlow_q;
   logic [7:0] hrel_q;
   logic [7:0] hprev_q;
   logic [7:0] dlow_q;
   logic [7:0] dgap_q;
   logic [7:0] hlow_d;
   logic [7:0] hrel_d;
   logic [7:0] hprev_d;
   logic [7:0] dlow_d;
   logic [7:0] dgap_d;

   // Counters saturate so that long idle gaps never wrap into a legal width.
   assign hlow_d  = host_oe ? hlow_q + {7'h00, hlow_q != 8'hff} : 8'h00;
   assign hrel_d  = host_oe ? 8'h00 : hrel_q + {7'h00, hrel_q != 8'hff};
   assign hprev_d = (!host_oe && hlow_q != 8'h00) ? hlow_q : hprev_q;
   assign dlow_d  = dev_oe ? dlow_q + {7'h00, dlow_q != 8'hff} : 8'h00;
   assign dgap_d  = (dev_oe && dlow_q == 8'h00) ? 8'h01 : dgap_q + {7'h00, dgap_q != 8'hff};

   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         hlow_q  <= 8'h00;
         hrel_q  <= 8'hff;
         hprev_q <= 8'h00;
         dlow_q  <= 8'h00;
         dgap_q  <= 8'hff;
      end else begin
         hlow_q  <= hlow_d;
         hrel_q  <= hrel_d;
         hprev_q <= hprev_d;
         dlow_q  <= dlow_d;
         dgap_q  <= dgap_d;
      end
   end

   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (RESET);

   a_host_pull_low: assert property (host_oe |-> !host_out)
      else $error("host drives the line high");
   a_dev_pull_low: assert property (dev_oe |-> !dev_out)
      else $error("device drives the line high");
   a_dev_responds_only: assert property ($rose(dev_oe) |-> !host_oe && $past(line))
      else $error("device pulled while the line was busy");
   a_dev_waits_cmd: assert property ($rose(dev_oe) |-> hrel_q >= SLOT_CYC)
      else $error("device drove before the command slot ended");
   a_host_pulse_width: assert property ($fell(host_oe) |->
      hlow_q == BRK_CYC || hlow_q == ZERO_CYC || hlow_q == ONE_CYC)
      else $error("host low pulse has a wrong width");
   a_brk_recovery: assert property ($rose(host_oe) && hprev_q == BRK_CYC |->
      hrel_q == REC_CYC)
      else $error("break recovery has a wrong length");
   a_host_slot_len: assert property ($rose(host_oe) && (hprev_q == ZERO_CYC ||
      hprev_q == ONE_CYC) |-> 9'(hprev_q) + 9'(hrel_q) == 9'(SLOT_CYC) || hrel_q > SLOT_CYC)
      else $error("host slot has a wrong length");
   a_dev_pulse_width: assert property ($fell(dev_oe) |->
      dlow_q == ZERO_CYC || dlow_q == ONE_CYC)
      else $error("device low pulse has a wrong width");
   a_dev_slot_len: assert property ($rose(dev_oe) |-> dgap_q >= SLOT_CYC)
      else $error("device slot is too short");
endmodule

// [tb/single_wire_rto_slave_link_tb.sv]
// Testbench joining the host and device ends over one shared line.
// Assumes swr_pkg and swr_if are compiled before this file.
`timescale 1ns/10ps
module single_wire_rto_slave_link_tb;
   import swr_pkg::*;
   localparam int BRK  = 2000;
   localparam int REC  = 400;
   localparam int SLOT = 1200;
   localparam int ZER  = 800;
   localparam int ONE  = 200;
   logic       MCLK, RESET, cfg, apply, force_cmd, sw_mode, wr_valid, wr_ready;
   logic       rd_req, rd_valid, req_valid, req_ready, req_write, rsp_valid, rsp_timeout;
   swr_code_t  wr_code, rd_code, req_code;
   swr_byte_t  wr_data, rd_data, req_data, rsp_data;
   logic [15:0] bits;
   int         num_errors, checks, lowc, nbits;
   swr_code_t  codes [4] = '{7'h00, 7'h7f, 7'h2a, 7'h55};

   swr_if link ();
   swr_host #(.BREAK_NS(BRK), .RECOVERY_NS(REC), .HOST_SLOT_NS(SLOT), .HOST_ZERO_NS(ZER),
      .HOST_ONE_NS(ONE), .BIT_THR_NS(500), .RD_TIMEOUT_NS(3000)) swr_host_inst (
      .MCLK(MCLK), .RESET(RESET), .LINK(link), .REQ_VALID(req_valid),
      .REQ_READY(req_ready), .REQ_WRITE(req_write), .REQ_CODE(req_code),
      .REQ_DATA(req_data), .RSP_VALID(rsp_valid), .RSP_TIMEOUT(rsp_timeout),
      .RSP_DATA(rsp_data));
   swr_dev #(.HOST_SLOT_NS(SLOT), .DEV_SLOT_NS(SLOT), .DEV_ZERO_NS(ZER), .DEV_ONE_NS(ONE),
      .BREAK_MIN_NS(1500), .BIT_THR_NS(500)) swr_dev_inst (
      .MCLK(MCLK), .RESET(RESET), .LINK(link), .CFG_SINGLE_WIRE(cfg),
      .APPLY_SEL_CMD(apply), .FORCE_SINGLE_WIRE_CMD(force_cmd), .SW_MODE(sw_mode),
      .WR_VALID(wr_valid), .WR_READY(wr_ready), .WR_CODE(wr_code), .WR_DATA(wr_data),
      .RD_REQ(rd_req), .RD_CODE(rd_code), .RD_VALID(rd_valid), .RD_DATA(rd_data));
   swr_link_assertions #(.BRK_CYC(BRK/20), .REC_CYC(REC/20), .SLOT_CYC(SLOT/20),
      .ZERO_CYC(ZER/20), .ONE_CYC(ONE/20)) swr_link_assertions_inst (
      .MCLK(MCLK), .RESET(RESET), .host_out(link.host_out), .host_oe(link.host_oe),
      .dev_out(link.dev_out), .dev_oe(link.dev_oe), .line(link.line));

   function automatic swr_byte_t rd_exp(input swr_code_t c);
      return {c[3:0], ~c[6:3]};
   endfunction

   // The core answers each read request half a cycle later, on the falling edge.
   always @(negedge MCLK) begin
      rd_valid = rd_req;
      rd_data  = rd_exp(rd_code);
   end

   always @(negedge MCLK) begin
      if (!link.line) lowc++;
      else if (lowc != 0) begin
         if (lowc > 2 * ZER / 20) nbits = 0;
         else begin
            if (nbits < 16) bits[nbits] = lowc < (ZER + ONE) / 40;
            nbits++;
         end
         lowc = 0;
      end
   end

   task automatic chk_bit(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk_byte(input swr_byte_t got, input swr_byte_t exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic stop_test;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic xfer(input logic wr, input swr_code_t code, input swr_byte_t data,
                       input logic to);
      int        n;
      swr_byte_t exp;
      exp = wr ? data : rd_exp(code);
      req_write = wr;
      req_code  = code;
      req_data  = data;
      req_valid = 1'b1;
      n = 0;
      while (req_ready !== 1'b1 && n < 100) begin
         @(negedge MCLK);
         n++;
      end
      @(negedge MCLK);
      req_valid = 1'b0;
      while (rsp_valid !== 1'b1 && n < 5000) begin
         @(negedge MCLK);
         n++;
      end
      if (n >= 5000) begin
         num_errors++;
         stop_test();
      end
      chk_bit(rsp_timeout, to);
      chk_byte(bits[7:0], {wr, code});
      chk_byte(8'(nbits), to ? 8'h08 : 8'h10);
      if (!to) chk_byte(bits[15:8], exp);
      if (!wr && !to) chk_byte(rsp_data, exp);
      if (!wr && !to) chk_byte({1'b0, rd_code}, {1'b0, code});
      repeat (100) @(negedge MCLK);
   endtask

   task automatic sel(input logic f, input logic c, input logic exp);
      cfg       = c;
      force_cmd = f;
      apply     = 1'b1;
      @(negedge MCLK);
      force_cmd = 1'b0;
      apply     = 1'b0;
      @(negedge MCLK);
      chk_bit(sw_mode, exp);
   endtask

   task automatic pop(input swr_code_t c, input swr_byte_t d);
      chk_bit(wr_valid, 1'b1);
      chk_byte({1'b0, wr_code}, {1'b0, c});
      chk_byte(wr_data, d);
      wr_ready = 1'b1;
      @(negedge MCLK);
      wr_ready = 1'b0;
      @(negedge MCLK);
   endtask

   initial begin
      MCLK = 1'b0;
      forever #10 MCLK = ~MCLK;
   end

   initial begin
      RESET = 1'b1;
      {cfg, apply, force_cmd, wr_ready, req_valid, req_write} = 6'h00;
      {req_code, req_data} = 15'h0;
      {num_errors, checks} = '0;
      repeat (16) @(negedge MCLK);
      RESET = 1'b0;
      repeat (4) @(negedge MCLK);
      chk_bit(sw_mode, 1'b0);
      xfer(1'b0, 7'h11, 8'h00, 1'b1);
      $display("test mode_off done");
      sel(1'b1, 1'b0, 1'b1);
      foreach (codes[i]) xfer(1'b0, codes[i], 8'h00, 1'b0);
      $display("test reads done");
      sel(1'b0, 1'b0, 1'b0);
      xfer(1'b0, 7'h33, 8'h00, 1'b1);
      sel(1'b0, 1'b1, 1'b1);
      $display("test select done");
      xfer(1'b1, 7'h01, 8'h3c, 1'b0);
      xfer(1'b1, 7'h7e, 8'hc3, 1'b0);
      xfer(1'b1, 7'h40, 8'h81, 1'b0);
      pop(7'h01, 8'h3c);
      pop(7'h7e, 8'hc3);
      chk_bit(wr_valid, 1'b0);
      xfer(1'b1, 7'h22, 8'h5a, 1'b0);
      pop(7'h22, 8'h5a);
      xfer(1'b0, 7'h22, 8'h00, 1'b0);
      $display("test writes done");
      stop_test();
   end
endmodule
